/* File: rtl/fspc_defs.svh */
// fspc_defs.svh: offsets, field positions, reset values and timing counts
// of the flash self-programming controller.
// assumes inclusion by bare name from the package and the design file.
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH

// ==========================================================================
// register byte offsets on apb
`define FSPC_OFS_CONTROL 12'h000
`define FSPC_OFS_KEY 12'h004
`define FSPC_OFS_PAGE 12'h008
`define FSPC_OFS_ADDR 12'h00C
`define FSPC_OFS_WDATA 12'h010
`define FSPC_OFS_TABLE 12'h014
`define FSPC_OFS_RDATA 12'h018
`define FSPC_OFS_STATUS 12'h01C

// ==========================================================================
// control register fields
`define FSPC_BIT_START 15
`define FSPC_BIT_ENABLE 14
`define FSPC_BIT_ERROR 13
`define FSPC_BIT_ERASE 6
`define FSPC_OPC_MSB 3
`define FSPC_CTRL_RESET 16'h0000

// table operation register fields
`define FSPC_TBL_GO 0
`define FSPC_TBL_WRITE 1
`define FSPC_TBL_HIGH 2
`define FSPC_TBL_BYTE 3

// ==========================================================================
// array geometry
`define FSPC_ROW_WORDS 64
`define FSPC_ROW_BYTES 192
`define FSPC_PAGE_WORDS 512
`define FSPC_PAGE_BYTES 1536

// unlock key values
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA

// ==========================================================================
// timing: 11064 rc oscillator cycles, rc at 7370 khz, pclk at 100000 khz
`define FSPC_RC_CYCLES 11064
`define FSPC_RC_KHZ 7370
`define FSPC_CLK_KHZ 100000
`define FSPC_OP_CYCLES ((`FSPC_RC_CYCLES * `FSPC_CLK_KHZ) / `FSPC_RC_KHZ)
// table write holds the core for two instruction cycles
`define FSPC_TBL_CYCLES 2

`endif

/* File: rtl/fspc_pkg.sv */
// fspc_pkg.sv: types of the flash self-programming controller.
// assumes fspc_defs.svh is on the include path.
`include "fspc_defs.svh"

package fspc_pkg;

  // ========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_TABLE = 2'b01,
    FSPC_BUSY = 2'b10
  } fspc_state_t;

  // unlock tracking
  typedef enum logic [1:0] {
    FSPC_KEY_NONE = 2'b00,
    FSPC_KEY_HALF = 2'b01,
    FSPC_KEY_FULL = 2'b10
  } fspc_key_t;

  // array command presented on the flash macro port
  typedef enum logic [2:0] {
    FSPC_CMD_NONE = 3'b000,
    FSPC_CMD_BULK = 3'b001,
    FSPC_CMD_SEGMENT = 3'b010,
    FSPC_CMD_PAGE = 3'b011,
    FSPC_CMD_CFG_ERASE = 3'b100,
    FSPC_CMD_WORD = 3'b101,
    FSPC_CMD_ROW = 3'b110,
    FSPC_CMD_CFG_PROG = 3'b111
  } fspc_cmd_t;

endpackage : fspc_pkg

/* File: rtl/fspc_ctrl.sv */
// fspc_ctrl.sv: run-time flash self-programming controller, apb slave.
// assumes a flash macro that accepts a one-cycle command strobe with the
// 24-bit target address and the row buffer, and a core that honours stall.
// assumes flash_read_data shows the word at the table address in the same
// clock, and that apb runs on pclk so no input needs a synchroniser.
// Function
// - rows hold 64 words of 192 bytes
// - pages and rows aligned at 1536/192 bytes
// - table write fills buffer only, two cycles
// - address is page byte joined to ea
// - low ops bits 15:0, high 23:16, byte mode
// - one start programs at most one row
// - core stalls while operation runs
// - operation lasts 11064 rc oscillator cycles
// - start bit launches, hardware clears it
// - software cannot clear start bit
// - key takes byte writes, reads zero
// - enable bit permits or inhibits operations
// - error flag marks bad sequence attempts
// - erase bit picks erase or program variant
// - erase codes: bulk, segment, page, config
// - program codes: word, row, config byte
// - other codes do nothing
// - control bits reset only on power-on
// - unimplemented control bits read zero
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "fspc_defs.svh"

module fspc_ctrl
  import fspc_pkg::*;
#(
  // pclk cycles of one array operation; shorten it in simulation
  parameter int OP_CYCLES = `FSPC_OP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_stall,
  output logic flash_cmd_valid,
  output fspc_cmd_t flash_cmd,
  output logic [23:0] flash_addr,
  output logic [24*`FSPC_ROW_WORDS-1:0] flash_row_data,
  input wire logic [23:0] flash_read_data
);

  // ========================================================================
  // state
  // every register resets only with presetn, which acts as power-on reset
  logic [15:0] ctrl_ff, nxt_ctrl;            // control register
  fspc_key_t key_ff, nxt_key;                // unlock progress
  logic [7:0] page_ff, nxt_page;             // table page register
  logic [15:0] ea_ff, nxt_ea;                // effective address
  logic [15:0] wdat_ff, nxt_wdat;            // table write operand
  logic [15:0] rdat_ff, nxt_rdat;            // table read result
  fspc_state_t st_ff, nxt_st;
  logic [23:0] cnt_ff, nxt_cnt;              // operation timer
  // holding buffer in flip-flops, one 24-bit word per slot
  logic [23:0] buf_ff [`FSPC_ROW_WORDS];     // holding buffer
  logic [23:0] nxt_buf [`FSPC_ROW_WORDS];
  logic [23:0] taddr_ff, nxt_taddr;          // latched target address
  fspc_cmd_t cmd_ff, nxt_cmd;
  logic cmdv_ff, nxt_cmdv;
  // the only source of bus read data; a flip-flop, loaded during reads
  logic [31:0] prdata_ff, nxt_prdata;

  // ========================================================================
  // bus decode; access completes in one access cycle while the sequencer is idle
  logic wr_acc, rd_acc, hit, is_tbl;
  logic [23:0] tgt;
  logic [5:0] slot;
  assign wr_acc = psel && penable && pwrite;
  // a read transfer in progress, setup and access cycles alike
  assign rd_acc = psel && !pwrite;
  // table page joined to effective address forms program address
  assign tgt = {page_ff, ea_ff};
  // program word index in row; addresses step by two per word
  assign slot = ea_ff[6:1];
  assign is_tbl = (st_ff == FSPC_TABLE);

  // every mapped offset answers; other offsets end in a slave error
  always_comb begin
    unique case (paddr)
      `FSPC_OFS_CONTROL, `FSPC_OFS_KEY, `FSPC_OFS_PAGE, `FSPC_OFS_ADDR,
      `FSPC_OFS_WDATA, `FSPC_OFS_TABLE, `FSPC_OFS_RDATA,
      `FSPC_OFS_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // stall the bus during a busy array cycle so the core waits
  // pready also drops for a table write, so the next access waits it out
  assign pready = !(st_ff == FSPC_BUSY) && !is_tbl;
  assign pslverr = psel && penable && !hit;
  assign core_stall = (st_ff != FSPC_IDLE);
  assign prdata = prdata_ff;
  assign flash_cmd_valid = cmdv_ff;
  assign flash_cmd = cmd_ff;
  assign flash_addr = taddr_ff;

  // the row leaves as one wide word, word i at bits 24*i upward
  genvar gi;
  generate
    for (gi = 0; gi < `FSPC_ROW_WORDS; gi++) begin : g_row
      assign flash_row_data[24*gi +: 24] = buf_ff[gi];
    end
  endgenerate

  // ========================================================================
  // decode of the operation code against the erase bit
  // codes outside both lists give no command but still run the timer,
  // so software sees the usual busy time and no array change
  function automatic fspc_cmd_t decode_op(input logic erase, input logic [3:0] op);
    fspc_cmd_t c;
    c = FSPC_CMD_NONE;
    if (erase) begin
      unique case (op)
        4'hF: c = FSPC_CMD_BULK;
        4'hD: c = FSPC_CMD_SEGMENT;
        4'h2: c = FSPC_CMD_PAGE;
        4'h0: c = FSPC_CMD_CFG_ERASE;
        default: c = FSPC_CMD_NONE;
      endcase
    end else begin
      unique case (op)
        4'h3: c = FSPC_CMD_WORD;
        4'h1: c = FSPC_CMD_ROW;
        4'h0: c = FSPC_CMD_CFG_PROG;
        default: c = FSPC_CMD_NONE;
      endcase
    end
    return c;
  endfunction : decode_op

  // ========================================================================
  // next-state logic for registers, key tracking and sequencer
  logic start_req;
  logic [15:0] wval;
  fspc_cmd_t dec;
  logic [23:0] aligned;
  always_comb begin
    // defaults: every register holds and the command strobe falls
    nxt_ctrl = ctrl_ff;
    nxt_key = key_ff;
    nxt_page = page_ff;
    nxt_ea = ea_ff;
    nxt_wdat = wdat_ff;
    nxt_rdat = rdat_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_taddr = taddr_ff;
    nxt_cmd = cmd_ff;
    nxt_cmdv = 1'b0;
    nxt_prdata = prdata_ff;
    for (int i = 0; i < `FSPC_ROW_WORDS; i++) begin
      nxt_buf[i] = buf_ff[i];
    end
    wval = pwdata[15:0];
    start_req = 1'b0;
    dec = decode_op(ctrl_ff[`FSPC_BIT_ERASE], ctrl_ff[`FSPC_OPC_MSB:0]);
    aligned = tgt;

    // software writes, taken while idle only; a write that meets a busy
    // sequencer waits in its access phase until pready rises
    if (wr_acc && pready && hit) begin
      // any write to a mapped offset other than the awaited key byte restarts unlock
      nxt_key = FSPC_KEY_NONE;
      unique case (paddr)
        `FSPC_OFS_CONTROL: begin
          // writable fields; unimplemented bits stay zero
          if (pstrb[0]) begin
            nxt_ctrl[`FSPC_BIT_ERASE] = wval[`FSPC_BIT_ERASE];
            nxt_ctrl[`FSPC_OPC_MSB:0] = wval[`FSPC_OPC_MSB:0];
          end
          if (pstrb[1]) begin
            nxt_ctrl[`FSPC_BIT_ENABLE] = wval[`FSPC_BIT_ENABLE];
            // error flag may be cleared or set by software
            nxt_ctrl[`FSPC_BIT_ERROR] = wval[`FSPC_BIT_ERROR];
            // start bit is set-only; a written zero is ignored
            start_req = wval[`FSPC_BIT_START];
          end
        end
        `FSPC_OFS_KEY: begin
          // only the low byte lane carries a key
          // a wrong byte or a wide write leaves the tracker at its start
          if (pstrb[0] && pstrb[3:1] == 3'b000) begin
            if (key_ff == FSPC_KEY_NONE && wval[7:0] == `FSPC_KEY_FIRST) begin
              nxt_key = FSPC_KEY_HALF;
            end else if (key_ff == FSPC_KEY_HALF && wval[7:0] == `FSPC_KEY_SECOND) begin
              nxt_key = FSPC_KEY_FULL;
            end
          end
        end
        `FSPC_OFS_PAGE: begin
          if (pstrb[0]) nxt_page = wval[7:0];
        end
        `FSPC_OFS_ADDR: begin
          if (pstrb[0]) nxt_ea[7:0] = wval[7:0];
          if (pstrb[1]) nxt_ea[15:8] = wval[15:8];
        end
        `FSPC_OFS_WDATA: begin
          if (pstrb[0]) nxt_wdat[7:0] = wval[7:0];
          if (pstrb[1]) nxt_wdat[15:8] = wval[15:8];
        end
        `FSPC_OFS_TABLE: begin
          if (pstrb[0] && wval[`FSPC_TBL_GO]) begin
            // table access; writes land in holding buffer only. the slot
            // comes from the effective address alone, so loading words of
            // one row group is left to software
            if (wval[`FSPC_TBL_WRITE]) begin
              if (wval[`FSPC_TBL_HIGH]) begin
                // high operations reach bits 23:16 only
                if (!wval[`FSPC_TBL_BYTE] || !ea_ff[0]) begin
                  nxt_buf[slot][23:16] = wdat_ff[7:0];
                end
              end else if (wval[`FSPC_TBL_BYTE]) begin
                // byte select picks the lane of the low word
                if (ea_ff[0]) nxt_buf[slot][15:8] = wdat_ff[7:0];
                else nxt_buf[slot][7:0] = wdat_ff[7:0];
              end else begin
                nxt_buf[slot][15:0] = wdat_ff;
              end
              // hold the core for the table write's two cycles
              nxt_st = FSPC_TABLE;
              nxt_cnt = 24'(`FSPC_TBL_CYCLES - 1);
            end else begin
              // reads come straight from the array; phantom byte is zero
              // the array answers in the same clock, so the result lands now
              if (wval[`FSPC_TBL_HIGH]) begin
                nxt_rdat = (wval[`FSPC_TBL_BYTE] && ea_ff[0]) ? 16'h0000 :
                  {8'h00, flash_read_data[23:16]};
              end else if (wval[`FSPC_TBL_BYTE]) begin
                nxt_rdat = {8'h00, ea_ff[0] ? flash_read_data[15:8] :
                  flash_read_data[7:0]};
              end else begin
                nxt_rdat = flash_read_data[15:0];
              end
            end
          end
        end
        default: begin
          nxt_key = FSPC_KEY_NONE;
        end
      endcase
    end

    // launching an operation; without the full key and the enable bit the
    // array never sees a command and only the error flag keeps the attempt.
    // the key state is used up by this write either way
    if (start_req) begin
      if (key_ff == FSPC_KEY_FULL && ctrl_ff[`FSPC_BIT_ENABLE]) begin
        // start bit stays set until the timer runs out
        nxt_ctrl[`FSPC_BIT_START] = 1'b1;
        nxt_ctrl[`FSPC_BIT_ERROR] = 1'b0;
        // align the target to the row or page it falls in; program
        // addresses step by two per word, so a row of 192 bytes spans
        // 128 address units and a page of 1536 bytes spans 1024
        if (dec == FSPC_CMD_ROW) begin
          // low address bits inside the row are dropped
          aligned = tgt & ~24'(2 * `FSPC_ROW_WORDS - 1);
        end else if (dec == FSPC_CMD_PAGE) begin
          // low address bits inside the page are dropped
          aligned = tgt & ~24'(2 * `FSPC_PAGE_WORDS - 1);
        end
        nxt_taddr = aligned;
        nxt_cmd = dec;
        nxt_cmdv = (dec != FSPC_CMD_NONE);
        nxt_st = FSPC_BUSY;
        nxt_cnt = 24'(OP_CYCLES - 1);
      end else begin
        // array untouched; flag the improper attempt
        nxt_ctrl[`FSPC_BIT_ERROR] = 1'b1;
      end
    end

    // sequencer countdown; a table write holds the core for two cycles and
    // an array operation for OP_CYCLES cycles, then the bus answers again
    unique case (st_ff)
      FSPC_IDLE: begin
      end
      // two-cycle hold of a table write
      FSPC_TABLE: begin
        if (cnt_ff == 24'h000000) nxt_st = FSPC_IDLE;
        else nxt_cnt = cnt_ff - 24'h000001;
      end
      FSPC_BUSY: begin
        if (cnt_ff == 24'h000000) begin
          nxt_st = FSPC_IDLE;
          // start bit falls at the edge where the sequencer goes idle
          nxt_ctrl[`FSPC_BIT_START] = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 24'h000001;
        end
      end
      default: nxt_st = FSPC_IDLE;
    endcase

    // read data; key reads zero, unused control bits read zero.
    // loaded on every cycle of a read transfer from the values that the
    // registers take at this edge, so in the completing cycle the flip-flop
    // already shows the current contents, even after a long stall
    if (rd_acc) begin
      unique case (paddr)
        `FSPC_OFS_CONTROL: nxt_prdata = {16'h0000, nxt_ctrl};
        // the key is write-only; none of it ever comes back
        `FSPC_OFS_KEY: nxt_prdata = 32'h00000000;
        `FSPC_OFS_PAGE: nxt_prdata = {24'h000000, nxt_page};
        `FSPC_OFS_ADDR: nxt_prdata = {16'h0000, nxt_ea};
        `FSPC_OFS_WDATA: nxt_prdata = {16'h0000, nxt_wdat};
        `FSPC_OFS_RDATA: nxt_prdata = {16'h0000, nxt_rdat};
        // status shows sequencer state above unlock progress
        `FSPC_OFS_STATUS: nxt_prdata = {28'h0000000, 2'(nxt_st), 2'(nxt_key)};
        // table operation register and holes read zero
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // the buffer is cleared at reset too, so a row started with a partly
  // loaded buffer programs known bits rather than unknowns
  // ========================================================================
  // registers; presetn stands for the power-on reset of the control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // control bits clear here only, as presetn is the power-on reset
      ctrl_ff <= `FSPC_CTRL_RESET;
      key_ff <= FSPC_KEY_NONE;
      page_ff <= 8'h00;
      ea_ff <= 16'h0000;
      wdat_ff <= 16'h0000;
      rdat_ff <= 16'h0000;
      st_ff <= FSPC_IDLE;
      cnt_ff <= 24'h000000;
      taddr_ff <= 24'h000000;
      cmd_ff <= FSPC_CMD_NONE;
      cmdv_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      for (int i = 0; i < `FSPC_ROW_WORDS; i++) begin
        buf_ff[i] <= 24'h000000;
      end
    end else begin
      // one register stage for every group, no clock enable
      ctrl_ff <= nxt_ctrl;
      key_ff <= nxt_key;
      page_ff <= nxt_page;
      ea_ff <= nxt_ea;
      wdat_ff <= nxt_wdat;
      rdat_ff <= nxt_rdat;
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      taddr_ff <= nxt_taddr;
      cmd_ff <= nxt_cmd;
      cmdv_ff <= nxt_cmdv;
      prdata_ff <= nxt_prdata;
      for (int i = 0; i < `FSPC_ROW_WORDS; i++) begin
        buf_ff[i] <= nxt_buf[i];
      end
    end
  end

endmodule : fspc_ctrl

/* File: test/fspc_flash_model.sv */
// fspc_flash_model.sv: behavioural flash array behind the controller.
// assumes one-cycle command strobes on pclk; erased words read all ones.
`timescale 1ns/1ns
module fspc_flash_model
  import fspc_pkg::*;
(
  input wire logic pclk,
  input wire logic cmd_valid,
  input fspc_cmd_t cmd,
  input wire logic [23:0] addr,
  input wire logic [1535:0] row_data,
  input wire logic [23:0] rd_addr,
  output logic [23:0] rd_data,
  output fspc_cmd_t last_cmd,
  output int n_cmd
);
  logic [23:0] mem [int]; // sparse array, absent means erased
  initial n_cmd = 0;
  initial last_cmd = FSPC_CMD_NONE;
  // =====================================================================
  // command execution
  always @(posedge pclk) begin
    if (cmd_valid) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= cmd;
      if (cmd == FSPC_CMD_ROW) begin
        for (int i = 0; i < 64; i++) mem[int'(addr) + 2 * i] = row_data[24 * i +: 24];
      end
      if (cmd == FSPC_CMD_PAGE) begin
        for (int i = 0; i < 512; i++) mem.delete(int'(addr) + 2 * i);
      end
      if (cmd == FSPC_CMD_BULK) mem.delete();
    end
  end
  // read port settles off the sampling edge
  always @(negedge pclk) begin
    rd_data <= mem.exists(int'(rd_addr)) ? mem[int'(rd_addr)] : 24'hFFFFFF;
  end
endmodule : fspc_flash_model

/* File: test/fspc_ctrl_assertions.sv */
// fspc_ctrl_assertions.sv: port checker of the controller.
// assumes OP_CYCLES small (tens of cycles) in simulation.
`timescale 1ns/1ns
module fspc_ctrl_assertions
  import fspc_pkg::*;
#(
  parameter int OP_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic core_stall,
  input logic flash_cmd_valid,
  input fspc_cmd_t flash_cmd
);
  localparam int MAXW = 60; // longest stall tolerated
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready; // completing apb edge
  // =====================================================================
  // assertions
  a_busy_waits: assert property (core_stall |-> !pready)
    else $error("ready while stalled");
  a_idle_ready: assert property (!core_stall |-> pready)
    else $error("ready low while idle");
  a_stall_bound: assert property ($rose(core_stall) |-> ##[1:MAXW] !core_stall)
    else $error("stall too long");
  a_op_holds: assert property (flash_cmd_valid |-> ##2 core_stall [*8])
    else $error("operation ended early");
  a_cmd_single: assert property (flash_cmd_valid |=> !flash_cmd_valid)
    else $error("command strobe repeated");
  a_start_cause: assert property (flash_cmd_valid |->
      $past(acc && pwrite && paddr == 12'h000 && pwdata[15]))
    else $error("command without start write");
  a_table_quiet: assert property (acc && pwrite && paddr == 12'h014
      |=> !flash_cmd_valid [*3])
    else $error("table write reached array");
  a_key_hidden: assert property (acc && !pwrite && paddr == 12'h004
      |-> prdata == 32'h00000000)
    else $error("key readable");
  a_ctrl_resv: assert property (acc && !pwrite && paddr == 12'h000 |->
      prdata[31:16] == 16'h0000 && prdata[12:7] == 6'h00 && prdata[5:4] == 2'h0)
    else $error("reserved control bits set");
  c_row: cover property (flash_cmd_valid && flash_cmd == FSPC_CMD_ROW);
  c_unmapped: cover property (acc && pslverr);
  c_done: cover property ($fell(core_stall));
endmodule : fspc_ctrl_assertions

bind fspc_ctrl fspc_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_stall(core_stall), .flash_cmd_valid(flash_cmd_valid), .flash_cmd(flash_cmd));

/* File: test/test_flash_self_program_controller.sv */
// test_flash_self_program_controller.sv: apb bench of the controller.
// assumes the flash model in place of the array; OP_CYCLES shortened.
`timescale 1ns/1ns
module test_flash_self_program_controller;
  import fspc_pkg::*;
  localparam int OPC = 20; // short operation time
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_stall, cvld, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [23:0] faddr, frd, rd_addr;
  logic [1535:0] row;
  fspc_cmd_t cmd, last_cmd, got;
  int n_cmd, n0, error_cnt, n_tests;
  logic [3:0] opc [12] = '{4'hF, 4'hD, 4'h3, 4'h2, 4'h1, 4'h0,
    4'hF, 4'hD, 4'h3, 4'h2, 4'h1, 4'h0};
  fspc_cmd_t exp [12] = '{FSPC_CMD_BULK, FSPC_CMD_SEGMENT, FSPC_CMD_NONE, FSPC_CMD_PAGE,
    FSPC_CMD_NONE, FSPC_CMD_CFG_ERASE, FSPC_CMD_NONE, FSPC_CMD_NONE, FSPC_CMD_WORD,
    FSPC_CMD_NONE, FSPC_CMD_ROW, FSPC_CMD_CFG_PROG};
  fspc_ctrl #(.OP_CYCLES(OPC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_stall(core_stall),
    .flash_cmd_valid(cvld), .flash_cmd(cmd), .flash_addr(faddr), .flash_row_data(row),
    .flash_read_data(frd));
  fspc_flash_model u_flash (.pclk(pclk), .cmd_valid(cvld), .cmd(cmd), .addr(faddr),
    .row_data(row), .rd_addr(rd_addr), .rd_data(frd), .last_cmd(last_cmd), .n_cmd(n_cmd));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // =====================================================================
  // reporting
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  // =====================================================================
  // apb transfer: setup, access until pready, one idle edge after
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    pstrb <= !w ? 4'h0 : (a == 12'h004 ? 4'h1 : 4'hF); // key takes one byte lane
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 200);
    err = pslverr;
    rd = prdata; // taken at the completing edge
    if (k >= 200) begin // bounded wait ran out
      chk("pready", 32'h1, 32'h0);
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic launch(input logic [31:0] c);
    wr(12'h000, c);
    wr(12'h004, 32'h55);
    wr(12'h004, 32'hAA);
    wr(12'h000, c | 32'h8000);
    repeat (2) @(posedge pclk); // two idle slots after the start
  endtask : launch
  // =====================================================================
  // main sequence
  initial begin
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata, rd_addr, error_cnt, n_tests} = '0;
    pstrb = 4'hF;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h000, 0);
    chk("ctl reset", 32'h0, rd);
    xfer(1'b0, 12'h004, 0);
    chk("key read", 32'h0, rd);
    xfer(1'b0, 12'h020, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(12'h000, 32'hFFFF7FFF);
    xfer(1'b0, 12'h000, 0);
    chk("ctl fields", 32'h604F, rd);
    $display("test registers done");
    n0 = n_cmd;
    wr(12'h000, 32'h4001);
    wr(12'h000, 32'hC001);
    xfer(1'b0, 12'h000, 0);
    chk("no key", 32'h6001, rd);
    wr(12'h000, 32'h4001);
    wr(12'h004, 32'h55);
    wr(12'h008, 32'h1);
    wr(12'h004, 32'hAA);
    wr(12'h000, 32'hC001);
    xfer(1'b0, 12'h000, 0);
    chk("broken key", 32'h6001, rd);
    launch(32'h0001);
    xfer(1'b0, 12'h000, 0);
    chk("no enable", 32'h2001, rd);
    chk("cmd count", n0, n_cmd);
    $display("test refusals done");
    for (int i = 0; i < 64; i++) begin
      wr(12'h00C, 32'h80 + 2 * i);
      wr(12'h010, 32'hA500 + i);
      wr(12'h014, 32'h3);
      wr(12'h010, 32'h10 + i);
      wr(12'h014, 32'h7);
    end
    chk("buffer only", n0, n_cmd);
    launch(32'h4001);
    chk("stall", 32'h1, {31'h0, core_stall});
    xfer(1'b0, 12'h000, 0);
    chk("row done", 32'h4001, rd);
    chk("resume", 32'h0, {31'h0, core_stall});
    chk("row cmd", FSPC_CMD_ROW, last_cmd);
    chk("row addr", 32'h010080, {8'h0, faddr});
    rd_addr <= 24'h010084;
    wr(12'h00C, 32'h84);
    wr(12'h014, 32'h1);
    xfer(1'b0, 12'h018, 0);
    chk("read low", 32'hA502, rd);
    wr(12'h014, 32'h5);
    xfer(1'b0, 12'h018, 0);
    chk("read high", 32'h12, rd);
    $display("test row done");
    for (int j = 0; j < 12; j++) begin
      n0 = n_cmd;
      launch(32'h4000 | (j < 6 ? 32'h40 : 32'h0) | opc[j]);
      xfer(1'b0, 12'h000, 0);
      got = (n_cmd != n0) ? last_cmd : FSPC_CMD_NONE;
      chk("op cmd", exp[j], got);
      if (j == 3) chk("page addr", 32'h010000, {8'h0, faddr});
    end
    $display("test opcodes done");
    tally_and_finish();
  end
endmodule : test_flash_self_program_controller
